// [cfm_core_regs.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Carry set on carry or borrow at bit7
// - Zero set when result is zero
// - Sign copies result MSB
// - Overflow set when signed result out of range
// - Decimal flag zero add, one subtract
// - Half carry on bit3 carry or borrow
// - Fast flag set during fast service
// - Fast flag cleared by interrupt return
// - Bank bit selects bank; bank instructions write it
// - Mask bit n enables level n
// - Level 0 is first timer counter
// - Level 1 is interval timer
// - Level 2 is second timer counter
// - Level 3 is display data channel
// - Levels 4-6 are external pins a-c
// - Level 7 is slave-only I2C controller
// - High pointer byte holds bits 15-8
// - Low pointer byte holds bits 7-0
module cfm_core_regs
  import cfm_pkg::*;
#(
  parameter int LEVELS = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire cfm_reg_req_t reg_req,
  input wire cfm_alu_t alu,
  input wire logic fast_service_enter,
  input wire logic return_from_interrupt_instr,
  input wire logic select_bank_zero_instr,
  input wire logic select_bank_one_instr,
  input wire logic first_timer_counter,
  input wire logic interval_timer,
  input wire logic second_timer_counter,
  input wire logic display_data_channel_ctrl,
  input wire logic external_pin_irq_a,
  input wire logic external_pin_irq_b,
  input wire logic external_pin_irq_c,
  input wire logic slave_i2c_irq,
  output logic [7:0] reg_rdata,
  output logic [7:0] status_byte,
  output logic [15:0] instruction_pointer,
  output logic [LEVELS-1:0] level_enabled_req,
  output logic bank_select
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cpu_status_byte_r;
  logic [7:0] cpu_status_byte_nxt;
  logic [7:0] interrupt_level_mask_r;
  logic [7:0] instr_pointer_high_r;
  logic [7:0] instr_pointer_low_r;
  logic [LEVELS-1:0] level_req_r;
  logic [7:0] reg_rdata_r;
  logic [LEVELS-1:0] level_raw;

  wire sel_status = reg_req.addr == CFM_OFS_STATUS;
  wire sel_mask = reg_req.addr == CFM_OFS_MASK;
  wire sel_ptr_high = reg_req.addr == CFM_OFS_PTR_HIGH;
  wire sel_ptr_low = reg_req.addr == CFM_OFS_PTR_LOW;
  wire wr_status = reg_req.wr && sel_status;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic: nine-bit sums give carry, borrow and signed range
  wire is_sub = alu.op == CFM_OP_SUB;
  wire alu_add = alu.valid && (alu.op == CFM_OP_ADD);
  wire alu_sub = alu.valid && is_sub;
  wire [8:0] add_full = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.carry_in};
  wire [8:0] sub_full = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.carry_in};
  wire [4:0] add_low = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.carry_in};
  wire [4:0] sub_low = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.carry_in};
  wire [8:0] full = is_sub ? sub_full : add_full;
  wire [7:0] result = full[7:0];
  wire carry_out = full[8];
  wire half_out = is_sub ? sub_low[4] : add_low[4];
  wire zero_out = result == 8'h00;
  wire sign_out = result[7];
  // Signed range exceeded when operands agree in sign (add) or differ (sub) and result sign differs from operand a
  wire ovfl_add = (alu.a[7] == alu.b[7]) && (result[7] != alu.a[7]);
  wire ovfl_sub = (alu.a[7] != alu.b[7]) && (result[7] != alu.a[7]);
  wire ovfl_out = is_sub ? ovfl_sub : ovfl_add;
  wire alu_upd = alu_add || alu_sub;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware events outrank a software write of the same bit
  always_comb begin
    cpu_status_byte_nxt = cpu_status_byte_r;
    if (wr_status) begin
      cpu_status_byte_nxt = reg_req.wdata;
    end
    if (alu_upd) begin
      cpu_status_byte_nxt[CFM_BIT_CARRY] = carry_out;
      cpu_status_byte_nxt[CFM_BIT_ZERO] = zero_out;
      cpu_status_byte_nxt[CFM_BIT_SIGN] = sign_out;
      cpu_status_byte_nxt[CFM_BIT_OVFL] = ovfl_out;
      cpu_status_byte_nxt[CFM_BIT_DEC] = is_sub;
      cpu_status_byte_nxt[CFM_BIT_HALF] = half_out;
    end
    if (return_from_interrupt_instr) begin
      cpu_status_byte_nxt[CFM_BIT_FAST] = 1'b0;
    end
    if (fast_service_enter) begin
      cpu_status_byte_nxt[CFM_BIT_FAST] = 1'b1;
    end
    if (select_bank_zero_instr) begin
      cpu_status_byte_nxt[CFM_BIT_BANK] = 1'b0;
    end
    if (select_bank_one_instr) begin
      cpu_status_byte_nxt[CFM_BIT_BANK] = 1'b1;
    end
  end

  // Flags other than fast and bank are undefined at reset; zero chosen here
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cpu_status_byte_r <= {6'h00, CFM_FAST_RST, CFM_BANK_RST};
    end else begin
      cpu_status_byte_r <= cpu_status_byte_nxt;
    end
  end

  // Mask and pointer keep no reset so software must load them
  always_ff @(posedge core_clk) begin
    if (reg_req.wr && sel_mask) begin
      interrupt_level_mask_r <= reg_req.wdata;
    end
    if (reg_req.wr && sel_ptr_high) begin
      instr_pointer_high_r <= reg_req.wdata;
    end
    if (reg_req.wr && sel_ptr_low) begin
      instr_pointer_low_r <= reg_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign level_raw[CFM_LEVEL_TIMER0] = first_timer_counter;
  assign level_raw[CFM_LEVEL_INTERVAL] = interval_timer;
  assign level_raw[CFM_LEVEL_TIMER1] = second_timer_counter;
  assign level_raw[CFM_LEVEL_DISPLAY] = display_data_channel_ctrl;
  assign level_raw[CFM_LEVEL_EXT_A] = external_pin_irq_a;
  assign level_raw[CFM_LEVEL_EXT_B] = external_pin_irq_b;
  assign level_raw[CFM_LEVEL_EXT_C] = external_pin_irq_c;
  assign level_raw[CFM_LEVEL_SLAVE] = slave_i2c_irq;

  genvar gi;
  generate
    for (gi = 0; gi < LEVELS; gi++) begin : g_level
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          level_req_r[gi] <= 1'b0;
        end else begin
          level_req_r[gi] <= level_raw[gi] && interrupt_level_mask_r[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] rd_mux = sel_status ? cpu_status_byte_r :
                      sel_mask ? interrupt_level_mask_r :
                      sel_ptr_high ? instr_pointer_high_r :
                      sel_ptr_low ? instr_pointer_low_r : 8'h00;

  // Unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign status_byte = cpu_status_byte_r;
  assign instruction_pointer = {instr_pointer_high_r, instr_pointer_low_r};
  assign level_enabled_req = level_req_r;
  assign bank_select = cpu_status_byte_r[CFM_BIT_BANK];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Arithmetic flags, one cycle after the strobe
  carry_update_a:
    assert property (alu_upd |=> status_byte[CFM_BIT_CARRY] == $past(carry_out))
    else $error("carry flag wrong");
  zero_update_a:
    assert property (alu_upd |=> status_byte[CFM_BIT_ZERO] == ($past(result) == 8'h00))
    else $error("zero flag wrong");
  sign_update_a:
    assert property (alu_upd |=> status_byte[CFM_BIT_SIGN] == $past(result[7]))
    else $error("sign flag wrong");
  ovfl_update_a:
    assert property (alu_upd |=> status_byte[CFM_BIT_OVFL] == $past(ovfl_out))
    else $error("overflow flag wrong");
  dec_kind_a:
    assert property (alu_sub |=> status_byte[CFM_BIT_DEC])
    else $error("decimal flag not set by subtract");
  dec_add_a:
    assert property (alu_add |=> !status_byte[CFM_BIT_DEC])
    else $error("decimal flag not cleared by add");
  half_update_a:
    assert property (alu_upd |=> status_byte[CFM_BIT_HALF] == $past(half_out))
    else $error("half carry wrong");

  // Fast service flag
  fast_set_a:
    assert property (fast_service_enter |=> status_byte[CFM_BIT_FAST])
    else $error("fast flag not set");
  fast_clear_a:
    assert property (return_from_interrupt_instr && !fast_service_enter
                     |=> !status_byte[CFM_BIT_FAST])
    else $error("fast flag not cleared");
  fast_hold_a:
    assert property (!fast_service_enter && !return_from_interrupt_instr && !wr_status
                     |=> $stable(status_byte[CFM_BIT_FAST]))
    else $error("fast flag changed without cause");

  // Bank select
  bank_one_a:
    assert property (select_bank_one_instr |=> bank_select)
    else $error("bank one not selected");
  bank_zero_a:
    assert property (select_bank_zero_instr && !select_bank_one_instr |=> !bank_select)
    else $error("bank zero not selected");
  bank_hold_a:
    assert property (!select_bank_zero_instr && !select_bank_one_instr && !wr_status
                     |=> $stable(bank_select))
    else $error("bank changed without cause");

  // Mask gating and source to level wiring
  mask_gate_a:
    assert property (!interrupt_level_mask_r[CFM_LEVEL_EXT_A]
                     |=> !level_enabled_req[CFM_LEVEL_EXT_A])
    else $error("masked level passed");
  mask_write_a:
    assert property (reg_req.wr && sel_mask |=> interrupt_level_mask_r == $past(reg_req.wdata))
    else $error("mask not written");
  timer0_level_a:
    assert property (first_timer_counter && interrupt_level_mask_r[CFM_LEVEL_TIMER0]
                     |=> level_enabled_req[CFM_LEVEL_TIMER0])
    else $error("first timer request lost");
  interval_level_a:
    assert property (interval_timer && interrupt_level_mask_r[CFM_LEVEL_INTERVAL]
                     |=> level_enabled_req[CFM_LEVEL_INTERVAL])
    else $error("interval request lost");
  timer1_level_a:
    assert property (second_timer_counter && interrupt_level_mask_r[CFM_LEVEL_TIMER1]
                     |=> level_enabled_req[CFM_LEVEL_TIMER1])
    else $error("second timer request lost");
  display_level_a:
    assert property (display_data_channel_ctrl && interrupt_level_mask_r[CFM_LEVEL_DISPLAY]
                     |=> level_enabled_req[CFM_LEVEL_DISPLAY])
    else $error("display channel request lost");
  ext_a_level_a:
    assert property (external_pin_irq_a && interrupt_level_mask_r[CFM_LEVEL_EXT_A]
                     |=> level_enabled_req[CFM_LEVEL_EXT_A])
    else $error("external pin a request lost");
  ext_b_level_a:
    assert property (external_pin_irq_b && interrupt_level_mask_r[CFM_LEVEL_EXT_B]
                     |=> level_enabled_req[CFM_LEVEL_EXT_B])
    else $error("external pin b request lost");
  ext_c_level_a:
    assert property (external_pin_irq_c && interrupt_level_mask_r[CFM_LEVEL_EXT_C]
                     |=> level_enabled_req[CFM_LEVEL_EXT_C])
    else $error("external pin c request lost");
  slave_level_a:
    assert property (slave_i2c_irq && interrupt_level_mask_r[CFM_LEVEL_SLAVE]
                     |=> level_enabled_req[CFM_LEVEL_SLAVE])
    else $error("slave controller request lost");

  // Every level is blocked by its own mask bit
  for (genvar gj = 0; gj < LEVELS; gj++) begin : g_level_chk
    level_block_a:
      assert property (!interrupt_level_mask_r[gj] |=> !level_enabled_req[gj])
      else $error("masked level passed");
  end

  // Pointer bytes, status write and register reads
  ptr_high_a:
    assert property (reg_req.wr && sel_ptr_high
                     |=> instruction_pointer[15:8] == $past(reg_req.wdata))
    else $error("pointer high not written");
  ptr_low_a:
    assert property (reg_req.wr && sel_ptr_low
                     |=> instruction_pointer[7:0] == $past(reg_req.wdata))
    else $error("pointer low not written");
  status_write_a:
    assert property (wr_status && !alu_upd |=> status_byte[7:2] == $past(reg_req.wdata[7:2]))
    else $error("status write lost");
  rdata_status_a:
    assert property (reg_req.rd && sel_status |=> reg_rdata == $past(status_byte))
    else $error("status read wrong");
  rdata_mask_a:
    assert property (reg_req.rd && sel_mask |=> reg_rdata == $past(interrupt_level_mask_r))
    else $error("mask read wrong");
  rdata_unmapped_a:
    assert property (reg_req.rd && !(sel_status || sel_mask || sel_ptr_high || sel_ptr_low)
                     |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a:
    assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  // Checked across reset itself, so its own disable is off
  reset_fast_a:
    assert property (disable iff (1'b0) !reset_n |=> !status_byte[CFM_BIT_FAST] && !bank_select)
    else $error("reset values wrong");

  add_seen_c: cover property (alu_add ##1 status_byte[CFM_BIT_CARRY]);
  sub_seen_c: cover property (alu_sub ##1 status_byte[CFM_BIT_OVFL]);
  fast_cycle_c: cover property (fast_service_enter ##[1:20] return_from_interrupt_instr);
  level_pass_c: cover property (level_enabled_req[CFM_LEVEL_DISPLAY]);
  bank_swap_c: cover property (select_bank_one_instr ##[1:20] select_bank_zero_instr);
endmodule : cfm_core_regs

// [cfm_core_regs_tb.sv]
`timescale 1ns/1ps
module cfm_core_regs_tb
  import cfm_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  cfm_reg_req_t reg_req = '0;
  cfm_alu_t alu = '0;
  logic [3:0] ctl = 4'h0;
  logic [7:0] irq_v = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] status_byte;
  logic [15:0] instruction_pointer;
  logic [7:0] level_enabled_req;
  logic bank_select;
  int fails = 0;
  int n_compared = 0;
  // Sub flag in bit 16, then operand a, then operand b
  logic [16:0] alu_cases [0:7] = '{17'h0ff01, 17'h07f01, 17'h00808, 17'h08080,
                                   17'h10001, 17'h18001, 17'h10505, 17'h11001};

  cfm_core_regs #(.LEVELS(8)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .alu(alu),
    .fast_service_enter(ctl[0]), .return_from_interrupt_instr(ctl[1]),
    .select_bank_zero_instr(ctl[2]), .select_bank_one_instr(ctl[3]),
    .first_timer_counter(irq_v[0]), .interval_timer(irq_v[1]),
    .second_timer_counter(irq_v[2]), .display_data_channel_ctrl(irq_v[3]),
    .external_pin_irq_a(irq_v[4]), .external_pin_irq_b(irq_v[5]),
    .external_pin_irq_c(irq_v[6]), .slave_i2c_irq(irq_v[7]),
    .reg_rdata(reg_rdata), .status_byte(status_byte),
    .instruction_pointer(instruction_pointer),
    .level_enabled_req(level_enabled_req), .bank_select(bank_select)
  );

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected flags, carry_in held at zero; low two bits (fast, bank) expected zero
  function automatic logic [7:0] flags(logic sub, logic [7:0] a, logic [7:0] b);
    logic [8:0] r;
    logic [4:0] h;
    r = sub ? {1'b0, a} - b : {1'b0, a} + b;
    h = sub ? {1'b0, a[3:0]} - b[3:0] : {1'b0, a[3:0]} + b[3:0];
    flags = {r[8], r[7:0] == 8'h00, r[7], (a[7] ^ r[7]) & (sub ^ (a[7] == b[7])), sub, h[4],
             2'b00};
  endfunction : flags

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd_chk

  task automatic ctl_pulse(input logic [3:0] v);
    @(posedge core_clk);
    ctl <= v;
    @(posedge core_clk);
    ctl <= 4'h0;
    #1;
  endtask : ctl_pulse

  task automatic irq_chk(input logic [7:0] v, input logic [7:0] exp);
    @(posedge core_clk);
    irq_v <= v;
    @(posedge core_clk);
    #1;
    chk({8'h00, level_enabled_req}, {8'h00, exp});
  endtask : irq_chk

  task automatic summarize;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({8'h00, status_byte}, 16'h0000);
    wr(CFM_OFS_PTR_HIGH, 8'h5a);
    wr(CFM_OFS_PTR_LOW, 8'hc3);
    chk(instruction_pointer, 16'h5ac3);
    rd_chk(CFM_OFS_PTR_HIGH, 8'h5a);
    rd_chk(CFM_OFS_PTR_LOW, 8'hc3);
    rd_chk(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      alu <= '{valid: 1'b1, op: alu_cases[i][16] ? CFM_OP_SUB : CFM_OP_ADD,
               a: alu_cases[i][15:8], b: alu_cases[i][7:0], carry_in: 1'b0};
      @(posedge core_clk);
      alu <= '0;
      #1;
      chk({8'h00, status_byte}, {8'h00, flags(alu_cases[i][16], alu_cases[i][15:8],
          alu_cases[i][7:0])});
    end
    ctl_pulse(4'h1);
    chk({15'h0, status_byte[CFM_BIT_FAST]}, 16'h0001);
    ctl_pulse(4'h2);
    chk({15'h0, status_byte[CFM_BIT_FAST]}, 16'h0000);
    // Simultaneous entry and return: entry wins
    ctl_pulse(4'h3);
    chk({15'h0, status_byte[CFM_BIT_FAST]}, 16'h0001);
    ctl_pulse(4'h8);
    chk({14'h0, bank_select, status_byte[CFM_BIT_BANK]}, 16'h0003);
    // Mid-run reset with fast flag and bank bit both set
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk({8'h00, status_byte}, 16'h0000);
    ctl_pulse(4'h4);
    chk({14'h0, bank_select, status_byte[CFM_BIT_BANK]}, 16'h0000);
    wr(CFM_OFS_MASK, 8'ha5);
    rd_chk(CFM_OFS_MASK, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      irq_chk(8'h01 << i, (8'h01 << i) & 8'ha5);
    end
    wr(CFM_OFS_MASK, 8'h5a);
    irq_chk(8'hff, 8'h5a);
    irq_chk(8'h00, 8'h00);
    wr(CFM_OFS_STATUS, 8'hfc);
    rd_chk(CFM_OFS_STATUS, 8'hfc);
    summarize();
  end
endmodule : cfm_core_regs_tb

// [cfm_pkg.sv]
package cfm_pkg;
  localparam logic [7:0] CFM_OFS_PTR_HIGH = 8'hda;
  localparam logic [7:0] CFM_OFS_PTR_LOW = 8'hdb;
  localparam logic [7:0] CFM_OFS_STATUS = 8'hd5;
  localparam logic [7:0] CFM_OFS_MASK = 8'hdd;
  localparam int CFM_BIT_CARRY = 7;
  localparam int CFM_BIT_ZERO = 6;
  localparam int CFM_BIT_SIGN = 5;
  localparam int CFM_BIT_OVFL = 4;
  localparam int CFM_BIT_DEC = 3;
  localparam int CFM_BIT_HALF = 2;
  localparam int CFM_BIT_FAST = 1;
  localparam int CFM_BIT_BANK = 0;
  localparam logic CFM_FAST_RST = 1'h0;
  localparam logic CFM_BANK_RST = 1'h0;
  localparam int CFM_LEVEL_TIMER0 = 0;
  localparam int CFM_LEVEL_INTERVAL = 1;
  localparam int CFM_LEVEL_TIMER1 = 2;
  localparam int CFM_LEVEL_DISPLAY = 3;
  localparam int CFM_LEVEL_EXT_A = 4;
  localparam int CFM_LEVEL_EXT_B = 5;
  localparam int CFM_LEVEL_EXT_C = 6;
  localparam int CFM_LEVEL_SLAVE = 7;

  typedef enum logic [1:0] {
    CFM_OP_ADD = 2'h1,
    CFM_OP_SUB = 2'h2
  } cfm_op_t;

  // One ALU operation and its operands offered for flag update
  typedef struct packed {
    logic valid;
    cfm_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
  } cfm_alu_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfm_reg_req_t;
endpackage : cfm_pkg
